// [logic/gsmc_ctl.sv]
`timescale 1ns/1ns
`default_nettype none
module gsmc_ctl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_bus,
	input wire logic [4:0] cfg_dev,
	input wire logic [2:0] cfg_func,
	input wire logic [7:0] cfg_offset,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	output logic cfg_ack,
	output logic cfg_hit,
	input wire logic system_mgmt_ram_ctl_lock_bit,
	input wire logic txt_lock,
	input wire logic me_stolen_lock,
	output logic [gsmc_pkg::GSMC_SEL_W-1:0] stolen_size_select,
	output logic vga_decode_disable,
	output logic [gsmc_pkg::GSMC_MB_W-1:0] stolen_size_mb,
	output logic stolen_size_reserved,
	output logic vga_claim,
	output logic [7:0] igfx_subclass,
	output logic size_locked
);
	import gsmc_pkg::*;

	gsmc_dec_if dif ();
	gsmc_sel_type next_sel;
	logic next_vga_dis;
	logic next_locked;
	logic [15:0] next_rdata;
	logic next_ack;
	logic next_hit;
	logic addr_hit;
	logic low_wr;

	gsmc_decode u_decode (
		.d(dif.dec)
	);

	assign dif.sel = stolen_size_select;
	assign dif.vga_dis = vga_decode_disable;

	always_comb begin
		addr_hit = (cfg_bus == GSMC_BUS) && (cfg_dev == GSMC_DEV) && (cfg_func == GSMC_FUNC)
			&& (cfg_offset == GSMC_GFX_CTL_OFFSET);
		low_wr = cfg_wr && addr_hit && cfg_be[0];
		next_locked = size_locked || system_mgmt_ram_ctl_lock_bit;
		next_sel = stolen_size_select;
		if (low_wr && !size_locked && !system_mgmt_ram_ctl_lock_bit) begin
			next_sel = cfg_wdata[GSMC_SEL_LSB +: GSMC_SEL_W];
		end
		next_vga_dis = vga_decode_disable;
		if (low_wr && !txt_lock && !me_stolen_lock) begin
			next_vga_dis = cfg_wdata[GSMC_VGA_DIS_BIT];
		end
		next_ack = cfg_rd || cfg_wr;
		next_hit = (cfg_rd || cfg_wr) && addr_hit;
		next_rdata = 16'h0000;
		if (cfg_rd && addr_hit) begin
			next_rdata = {8'h00, GSMC_LOW_BYTE_MASK & {stolen_size_select, 2'b00, vga_decode_disable, 1'b0}};
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stolen_size_select <= GSMC_GFX_CTL_RESET[GSMC_SEL_LSB +: GSMC_SEL_W];
			vga_decode_disable <= GSMC_GFX_CTL_RESET[GSMC_VGA_DIS_BIT];
			size_locked <= 1'b0;
			cfg_rdata <= 16'h0000;
			cfg_ack <= 1'b0;
			cfg_hit <= 1'b0;
			stolen_size_mb <= '0;
			stolen_size_reserved <= 1'b0;
			vga_claim <= 1'b0;
			igfx_subclass <= GSMC_SUBCLASS_OTHER;
		end else begin
			stolen_size_select <= next_sel;
			vga_decode_disable <= next_vga_dis;
			size_locked <= next_locked;
			cfg_rdata <= next_rdata;
			cfg_ack <= next_ack;
			cfg_hit <= next_hit;
			stolen_size_mb <= dif.size_mb;
			stolen_size_reserved <= dif.reserved;
			vga_claim <= dif.claim;
			igfx_subclass <= dif.subclass;
		end
	end
endmodule : gsmc_ctl
`default_nettype wire

// [logic/gsmc_dec_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface gsmc_dec_if;
	import gsmc_pkg::*;
	gsmc_sel_type sel;
	logic vga_dis;
	gsmc_mb_type size_mb;
	logic reserved;
	logic claim;
	logic [7:0] subclass;
	modport ctl (output sel, output vga_dis, input size_mb, input reserved, input claim, input subclass);
	modport dec (input sel, input vga_dis, output size_mb, output reserved, output claim, output subclass);
endinterface : gsmc_dec_if
`default_nettype wire

// [logic/gsmc_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module gsmc_decode (
	gsmc_dec_if.dec d
);
	import gsmc_pkg::*;

	function automatic gsmc_mb_type size_of(input gsmc_sel_type s);
		unique case (s)
			GSMC_SEL_32: size_of = 9'd32;
			GSMC_SEL_48: size_of = 9'd48;
			GSMC_SEL_64: size_of = 9'd64;
			GSMC_SEL_128: size_of = 9'd128;
			GSMC_SEL_256: size_of = 9'd256;
			GSMC_SEL_96: size_of = 9'd96;
			GSMC_SEL_160: size_of = 9'd160;
			GSMC_SEL_224: size_of = 9'd224;
			GSMC_SEL_352: size_of = 9'd352;
			default: size_of = 9'd0;
		endcase
	endfunction : size_of

	always_comb begin
		d.size_mb = size_of(d.sel);
		d.reserved = (d.sel != GSMC_SEL_NONE) && (size_of(d.sel) == 9'd0);
		d.claim = !d.vga_dis && (d.sel != GSMC_SEL_NONE);
		d.subclass = d.claim ? GSMC_SUBCLASS_VGA : GSMC_SUBCLASS_OTHER;
	end
endmodule : gsmc_decode
`default_nettype wire

// [logic/gsmc_pkg.sv]
// Overview of operation
// - Bits 7:4 hold a read/write stolen-size select that resets to 0011b.
// - Select 0000 pre-allocates nothing, stops VGA claiming and reports sub-class 80h.
// - Select 0101, 0110, 1000 and 1001 give 32, 48, 128 and 256 MB of frame buffer.
// - Select 1010, 1011, 1100 and 1101 give 96, 160, 224 and 352 MB in total.
// - Once the system-management RAM lock is seen, the select ignores writes until reset.
// - The select changes only by software writes, never when graphics is enabled or disabled.
// - With VGA-decode-disable at 0 and a nonzero select the graphics function claims VGA cycles and reports sub-class 00h.
// - With VGA-decode-disable at 1 the graphics function claims no VGA cycles and reports sub-class 80h.
// - VGA-decode-disable is read-only while the trusted-execution or stolen-memory lock is active.
// - The register is 16 bits at configuration offset 52h of bus 0, device 0, function 0, reset 0030h.
package gsmc_pkg;
	localparam logic [7:0] GSMC_BUS = 8'h00;
	localparam logic [4:0] GSMC_DEV = 5'h00;
	localparam logic [2:0] GSMC_FUNC = 3'h0;
	localparam logic [7:0] GSMC_GFX_CTL_OFFSET = 8'h52;
	localparam logic [15:0] GSMC_GFX_CTL_RESET = 16'h0030;
	localparam int GSMC_SEL_LSB = 4;
	localparam int GSMC_SEL_W = 4;
	localparam int GSMC_VGA_DIS_BIT = 1;
	localparam logic [7:0] GSMC_LOW_BYTE_MASK = 8'hF2;
	localparam logic [7:0] GSMC_SUBCLASS_VGA = 8'h00;
	localparam logic [7:0] GSMC_SUBCLASS_OTHER = 8'h80;
	localparam int GSMC_MB_W = 9;
	localparam logic [3:0] GSMC_SEL_NONE = 4'h0;
	localparam logic [3:0] GSMC_SEL_32 = 4'h5;
	localparam logic [3:0] GSMC_SEL_48 = 4'h6;
	localparam logic [3:0] GSMC_SEL_64 = 4'h7;
	localparam logic [3:0] GSMC_SEL_128 = 4'h8;
	localparam logic [3:0] GSMC_SEL_256 = 4'h9;
	localparam logic [3:0] GSMC_SEL_96 = 4'hA;
	localparam logic [3:0] GSMC_SEL_160 = 4'hB;
	localparam logic [3:0] GSMC_SEL_224 = 4'hC;
	localparam logic [3:0] GSMC_SEL_352 = 4'hD;
	typedef logic [GSMC_SEL_W-1:0] gsmc_sel_type;
	typedef logic [GSMC_MB_W-1:0] gsmc_mb_type;
endpackage : gsmc_pkg

// [testbench/gsmc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module gsmc_checker (
	input wire logic core_clk, rst, cfg_rd, cfg_wr, cfg_ack,
	input wire logic [15:0] cfg_rdata,
	input wire logic system_mgmt_ram_ctl_lock_bit, txt_lock, me_stolen_lock, vga_decode_disable, vga_claim,
	input wire logic [3:0] stolen_size_select,
	input wire logic [8:0] stolen_size_mb,
	input wire logic [7:0] igfx_subclass
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	ack_latency_a: assert property ((cfg_rd || cfg_wr) |=> cfg_ack) else $error("ack missing");
	subclass_map_a: assert property (igfx_subclass == (vga_claim ? 8'h00 : 8'h80)) else $error("bad subclass");
	claim_src_a: assert property (!$past(rst) |-> vga_claim == $past(!vga_decode_disable && stolen_size_select != 4'h0))
		else $error("bad claim");
	size_map_a: assert property (!$past(rst) && $past(stolen_size_select) == 4'h9 |-> stolen_size_mb == 9'd256)
		else $error("bad size");
	sel_lock_a: assert property (system_mgmt_ram_ctl_lock_bit |=> $stable(stolen_size_select)) else $error("select moved");
	vga_lock_a: assert property ((txt_lock || me_stolen_lock) |=> $stable(vga_decode_disable)) else $error("vga moved");
	rsvd_zero_a: assert property (cfg_ack |-> cfg_rdata[15:8] == 8'h00 && cfg_rdata[3:2] == 2'b00 && !cfg_rdata[0])
		else $error("reserved set");
	sel_hold_a: assert property (!cfg_wr |=> $stable(stolen_size_select)) else $error("select drift");
endmodule : gsmc_checker
bind gsmc_ctl gsmc_checker u_gsmc_checker (.core_clk, .rst, .cfg_rd, .cfg_wr, .cfg_ack, .cfg_rdata, .system_mgmt_ram_ctl_lock_bit,
	.txt_lock, .me_stolen_lock, .vga_decode_disable, .vga_claim, .stolen_size_select, .stolen_size_mb, .igfx_subclass);
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic core_clk = 0, rst = 1, cfg_rd = 0, cfg_wr = 0, system_mgmt_ram_ctl_lock_bit = 0, txt_lock = 0, me_stolen_lock = 0;
	logic [7:0] cfg_offset = 8'h52, igfx_subclass;
	logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, rd_q;
	logic cfg_ack, cfg_hit, hit_q, vga_decode_disable, stolen_size_reserved, vga_claim, size_locked;
	logic [1:0] cfg_be = 2'b01;
	logic [3:0] stolen_size_select;
	logic [8:0] stolen_size_mb;
	logic [3:0] codes [12] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h1, 4'hE};
	logic [8:0] mbs [12] = '{9'd0, 9'd32, 9'd48, 9'd64, 9'd128, 9'd256, 9'd96, 9'd160, 9'd224, 9'd352, 9'd0, 9'd0};
	int err_count = 0, checks = 0, cyc = 0;
	always #50 core_clk = ~core_clk;
	gsmc_ctl u_gsmc_ctl (.core_clk, .rst, .cfg_rd, .cfg_wr, .cfg_bus(8'h00), .cfg_dev(5'h00), .cfg_func(3'h0),
		.cfg_offset, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .cfg_hit, .system_mgmt_ram_ctl_lock_bit, .txt_lock,
		.me_stolen_lock, .stolen_size_select, .vga_decode_disable, .stolen_size_mb, .stolen_size_reserved,
		.vga_claim, .igfx_subclass, .size_locked);
	task automatic end_sim;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// request at a falling edge, answer sampled one falling edge later
	task automatic acc(input logic r, input logic w, input logic [7:0] off, input logic [15:0] d);
		cfg_rd = r;
		cfg_wr = w;
		cfg_offset = off;
		cfg_wdata = d;
		@(negedge core_clk);
		rd_q = cfg_rdata;
		hit_q = cfg_hit;
		chk({15'h0, cfg_ack}, 16'h0001);
		cfg_rd = 0;
		cfg_wr = 0;
		@(negedge core_clk);
	endtask : acc
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rst = 0;
		acc(1, 0, 8'h52, 16'h0000);
		chk(rd_q, 16'h0030);
		chk({15'h0, hit_q}, 16'h0001);
		chk({15'h0, size_locked}, 16'h0000);
		acc(0, 1, 8'h52, 16'hFFFF);
		acc(1, 0, 8'h52, 16'h0000);
		chk(rd_q, 16'h00F2);
		for (int i = 0; i < 12; i++) begin
			// select 0000 only ever written with the vga decode disabled
			acc(0, 1, 8'h52, {8'h00, codes[i], 4'h2});
			chk({6'h0, stolen_size_reserved, stolen_size_mb}, {6'h0, i > 9, mbs[i]});
			chk({7'h0, vga_claim, igfx_subclass}, 16'h0080);
		end
		acc(0, 1, 8'h52, 16'h0050);
		chk({7'h0, vga_claim, igfx_subclass}, 16'h0100);
		acc(0, 1, 8'h54, 16'h0082);
		chk({hit_q, 7'h0, stolen_size_select, 3'h0, vga_decode_disable}, 16'h0050);
		cfg_be = 2'b10;
		acc(0, 1, 8'h52, 16'h0092);
		chk({stolen_size_select, 3'h0, vga_decode_disable}, 16'h0050);
		cfg_be = 2'b01;
		for (int j = 0; j < 2; j++) begin
			{txt_lock, me_stolen_lock} = j ? 2'b01 : 2'b10;
			acc(0, 1, 8'h52, 16'h0072);
			chk({stolen_size_select, 3'h0, vga_decode_disable}, 16'h0070);
			{txt_lock, me_stolen_lock} = 2'b00;
			acc(0, 1, 8'h52, 16'h0050);
		end
		system_mgmt_ram_ctl_lock_bit = 1;
		acc(0, 1, 8'h52, 16'h0092);
		system_mgmt_ram_ctl_lock_bit = 0;
		acc(0, 1, 8'h52, 16'h0082);
		chk({stolen_size_select, 3'h0, vga_decode_disable}, 16'h0051);
		chk({15'h0, size_locked}, 16'h0001);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
